// >>> design/ttc_consts.vh
// Purpose: Constants for the triple timer/counter unit: register addresses,
//          field positions, reset values and mode codes.
// Assumes: Included by the unit's design files by bare name.
// Notes:   Definitions only.
`ifndef TTC_CONSTS_VH
`define TTC_CONSTS_VH

// Register addresses on the core's special function register port
`define TTC_ADDR_CONTROL 8'h88
`define TTC_ADDR_MODE 8'h89
`define TTC_ADDR_T0_LOW 8'h8a
`define TTC_ADDR_T1_LOW 8'h8b
`define TTC_ADDR_T0_HIGH 8'h8c
`define TTC_ADDR_T1_HIGH 8'h8d
`define TTC_ADDR_T2_CONTROL 8'hc8
`define TTC_ADDR_T2_RELOAD_LOW 8'hca
`define TTC_ADDR_T2_RELOAD_HIGH 8'hcb
`define TTC_ADDR_T2_LOW 8'hcc
`define TTC_ADDR_T2_HIGH 8'hcd

// Control register fields
`define TTC_CTL_T1_FLAG 7
`define TTC_CTL_T1_RUN 6
`define TTC_CTL_T0_FLAG 5
`define TTC_CTL_T0_RUN 4

// Mode register fields
`define TTC_MOD_T1_GATING 7
`define TTC_MOD_T1_SOURCE 6
`define TTC_MOD_T1_MODE_HI 5
`define TTC_MOD_T1_MODE_LO 4
`define TTC_MOD_T0_GATING 3
`define TTC_MOD_T0_SOURCE 2
`define TTC_MOD_T0_MODE_HI 1
`define TTC_MOD_T0_MODE_LO 0

// Mode codes
`define TTC_MODE_PRESCALE 2'b00
`define TTC_MODE_CASCADE 2'b01
`define TTC_MODE_AUTORELOAD 2'b10
`define TTC_MODE_SPLIT 2'b11

// Prescaler width and terminal value in the prescale mode
`define TTC_PRESCALE_BITS 5
`define TTC_PRESCALE_LAST 5'h1f

// Reset values
`define TTC_RST_BYTE 8'h00
`define TTC_RST_MODE 2'b00

`endif

// >>> design/ttc_count_unit.v
// Purpose: One 16-bit timer/counter made of a low and a high byte, with the
//          four counting modes selected by a 2-bit mode field.
// Assumes: lowInc is already qualified by run, gate and source; highInc by a run bit only.
// Notes:   A software write to a byte wins over counting in the same cycle.
`timescale 1ns/10ps
`include "ttc_consts.vh"

module ttc_count_unit (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Control
   input wire [1:0] mode,
   input wire lowInc,
   input wire highInc,
   // Software writes
   input wire wrLow,
   input wire wrHigh,
   input wire [7:0] wrData,
   // Count state
   output wire [7:0] lowByte,
   output wire [7:0] highByte,
   output reg mainOvf,
   output reg highOvf
);

   reg [7:0] low_reg;
   reg [7:0] high_reg;
   reg [7:0] low_next;
   reg [7:0] high_next;

   assign lowByte = low_reg;
   assign highByte = high_reg;

   always @* begin
      low_next = low_reg;
      high_next = high_reg;
      mainOvf = 1'b0;
      highOvf = 1'b0;
      case (mode)
         `TTC_MODE_PRESCALE: begin
            if (lowInc) begin
               low_next[`TTC_PRESCALE_BITS-1:0] = low_reg[`TTC_PRESCALE_BITS-1:0] + 5'h01;
               if (low_reg[`TTC_PRESCALE_BITS-1:0] == `TTC_PRESCALE_LAST) begin
                  high_next = high_reg + 8'h01;
                  mainOvf = (high_reg == 8'hff);
               end
            end
         end
         `TTC_MODE_CASCADE: begin
            if (lowInc) begin
               {high_next, low_next} = {high_reg, low_reg} + 16'h0001;
               mainOvf = ({high_reg, low_reg} == 16'hffff);
            end
         end
         `TTC_MODE_AUTORELOAD: begin
            if (lowInc) begin
               if (low_reg == 8'hff) begin
                  low_next = high_reg;
                  mainOvf = 1'b1;
               end else begin
                  low_next = low_reg + 8'h01;
               end
            end
         end
         default: begin
            if (lowInc) begin
               low_next = low_reg + 8'h01;
               mainOvf = (low_reg == 8'hff);
            end
            if (highInc) begin
               high_next = high_reg + 8'h01;
               highOvf = (high_reg == 8'hff);
            end
         end
      endcase
      if (wrLow) begin
         low_next = wrData;
      end
      if (wrHigh) begin
         high_next = wrData;
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         low_reg <= `TTC_RST_BYTE;
         high_reg <= `TTC_RST_BYTE;
      end else begin
         low_reg <= low_next;
         high_reg <= high_next;
      end
   end

endmodule // ttc_count_unit

// >>> design/ttc_timer_unit.v
// Purpose: Three 16-bit timer/counters reached as special function
//          registers of the core, with pin gating and event counting.
// Assumes: One core clock; a machine cycle is one clock period.
// Notes:   Timer 2 bytes are plain storage; its counting lies elsewhere.
//
// What this block does
// - Three 16-bit counters, byte-addressable, timer/counter
// - Timer mode increments low byte each cycle
// - Count rate at most one per clock
// - Counter mode counts sampled falling edges
// - Edge recognition takes two cycles
// - Timer 1 gating by pin and run
// - Mode bit 6 selects timer 1 source
// - Mode fields reset 00; prescale mode
// - Mode 01 is plain 16-bit
// - Mode 10 autoreloads low from high
// - Timer 1 mode 11 stops, holds value
// - Timer 0 mode 11 splits bytes
// - Timer 0 gating by pin and run
// - Mode bit 2 selects timer 0 source
// - Overflow sets flag; vectoring clears it
// - Run bits start and stop timers
`timescale 1ns/10ps
`include "ttc_consts.vh"

module ttc_timer_unit (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Special function register port
   input wire [7:0] sfrAddr,
   input wire sfrWrEn,
   input wire [7:0] sfrWrData,
   input wire sfrRdEn,
   output reg [7:0] sfrRdData,
   // Interrupt vector acknowledges from the core
   input wire timer0VectorAck,
   input wire timer1VectorAck,
   // External pins
   input wire countInputZero,
   input wire countInputOne,
   input wire gatePinZero,
   input wire gatePinOne,
   // Overflow flags toward the interrupt logic
   output reg timer0OverflowFlag,
   output reg timer1OverflowFlag
);

   localparam PIN_COUNT = 4;
   localparam PIN_CNT0 = 0;
   localparam PIN_CNT1 = 1;
   localparam PIN_TIMER0_PIN_GATING = 2;
   localparam PIN_TIMER1_PIN_GATING = 3;

   // Pin synchronisers and edge history
   wire [PIN_COUNT-1:0] pinRaw;
   wire [PIN_COUNT-1:0] pinSync;
   wire [PIN_COUNT-1:0] pinFall;

   // Software-visible state
   reg timer1Run_reg;
   reg timer0Run_reg;
   reg [3:0] extIntBits_reg;
   reg [7:0] mode_reg;
   reg [7:0] t2Control_reg;
   reg [7:0] t2ReloadLow_reg;
   reg [7:0] t2ReloadHigh_reg;
   reg [7:0] t2Low_reg;
   reg [7:0] t2High_reg;

   // Decoded mode fields
   wire timer1PinGating;
   wire timer1SourceSelect;
   wire [1:0] timer1Mode;
   wire timer0PinGating;
   wire timer0SourceSelect;
   wire [1:0] timer0Mode;

   // Count qualification
   wire timer0Enable;
   wire timer1Enable;
   wire timer0Tick;
   wire timer1Tick;
   wire timer0LowInc;
   wire timer1LowInc;
   wire timer0HighInc;

   // Counter state
   wire [7:0] timer0Low;
   wire [7:0] timer0High;
   wire [7:0] timer1Low;
   wire [7:0] timer1High;
   wire timer0MainOvf;
   wire timer0HighOvf;
   wire timer1MainOvf;
   wire timer0OvfEvent;
   wire timer1OvfEvent;

   // Write strobes
   wire wrControl;
   wire wrMode;
   wire wrT0Low;
   wire wrT0High;
   wire wrT1Low;
   wire wrT1High;

   reg timer0Flag_next;
   reg timer1Flag_next;
   reg [7:0] readMux;

   assign pinRaw = {gatePinOne, gatePinZero, countInputOne, countInputZero};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : gPin
         reg pinMeta_reg, pinSync_reg, pinPrev_reg;
         always @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               pinMeta_reg <= 1'b0;
               pinSync_reg <= 1'b0;
               pinPrev_reg <= 1'b0;
            end else begin
               pinMeta_reg <= pinRaw[gi];
               pinSync_reg <= pinMeta_reg;
               pinPrev_reg <= pinSync_reg;
            end
         end
         assign pinSync[gi] = pinSync_reg;
         assign pinFall[gi] = pinPrev_reg & ~pinSync_reg;
      end
   endgenerate

   assign timer1PinGating = mode_reg[`TTC_MOD_T1_GATING];
   assign timer1SourceSelect = mode_reg[`TTC_MOD_T1_SOURCE];
   assign timer1Mode = mode_reg[`TTC_MOD_T1_MODE_HI:`TTC_MOD_T1_MODE_LO];
   assign timer0PinGating = mode_reg[`TTC_MOD_T0_GATING];
   assign timer0SourceSelect = mode_reg[`TTC_MOD_T0_SOURCE];
   assign timer0Mode = mode_reg[`TTC_MOD_T0_MODE_HI:`TTC_MOD_T0_MODE_LO];

   // timer 0 gate pin and run bit
   assign timer0Enable = timer0Run_reg & (~timer0PinGating | pinSync[PIN_TIMER0_PIN_GATING]);
   // timer 1 gate pin and run bit
   assign timer1Enable = timer1Run_reg & (~timer1PinGating | pinSync[PIN_TIMER1_PIN_GATING]);

   assign timer0Tick = timer0SourceSelect ? pinFall[PIN_CNT0] : 1'b1;
   assign timer1Tick = timer1SourceSelect ? pinFall[PIN_CNT1] : 1'b1;

   assign timer0LowInc = timer0Enable & timer0Tick;
   assign timer1LowInc = timer1Enable & timer1Tick & (timer1Mode != `TTC_MODE_SPLIT);
   // split high byte follows timer 1 run bit, clock only
   assign timer0HighInc = (timer0Mode == `TTC_MODE_SPLIT) & timer1Run_reg;

   assign wrControl = sfrWrEn & (sfrAddr == `TTC_ADDR_CONTROL);
   assign wrMode = sfrWrEn & (sfrAddr == `TTC_ADDR_MODE);
   assign wrT0Low = sfrWrEn & (sfrAddr == `TTC_ADDR_T0_LOW);
   assign wrT0High = sfrWrEn & (sfrAddr == `TTC_ADDR_T0_HIGH);
   assign wrT1Low = sfrWrEn & (sfrAddr == `TTC_ADDR_T1_LOW);
   assign wrT1High = sfrWrEn & (sfrAddr == `TTC_ADDR_T1_HIGH);

   ttc_count_unit uTimer0 (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .mode(timer0Mode),
      .lowInc(timer0LowInc),
      .highInc(timer0HighInc),
      .wrLow(wrT0Low),
      .wrHigh(wrT0High),
      .wrData(sfrWrData),
      .lowByte(timer0Low),
      .highByte(timer0High),
      .mainOvf(timer0MainOvf),
      .highOvf(timer0HighOvf)
   );

   ttc_count_unit uTimer1 (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .mode(timer1Mode),
      .lowInc(timer1LowInc),
      .highInc(1'b0),
      .wrLow(wrT1Low),
      .wrHigh(wrT1High),
      .wrData(sfrWrData),
      .lowByte(timer1Low),
      .highByte(timer1High),
      .mainOvf(timer1MainOvf),
      .highOvf()
   );

   // While timer 0 is split, its high byte owns the timer 1 flag
   assign timer0OvfEvent = timer0MainOvf;
   assign timer1OvfEvent = (timer0Mode == `TTC_MODE_SPLIT) ? timer0HighOvf : timer1MainOvf;

   // set beats clear on the same edge
   always @* begin
      timer0Flag_next = timer0OverflowFlag;
      timer1Flag_next = timer1OverflowFlag;
      if (timer0VectorAck) begin
         timer0Flag_next = 1'b0;
      end
      if (timer1VectorAck) begin
         timer1Flag_next = 1'b0;
      end
      if (wrControl) begin
         timer0Flag_next = sfrWrData[`TTC_CTL_T0_FLAG];
         timer1Flag_next = sfrWrData[`TTC_CTL_T1_FLAG];
      end
      if (timer0OvfEvent) begin
         timer0Flag_next = 1'b1;
      end
      if (timer1OvfEvent) begin
         timer1Flag_next = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timer0OverflowFlag <= 1'b0;
         timer1OverflowFlag <= 1'b0;
      end else begin
         timer0OverflowFlag <= timer0Flag_next;
         timer1OverflowFlag <= timer1Flag_next;
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timer1Run_reg <= 1'b0;
         timer0Run_reg <= 1'b0;
         extIntBits_reg <= 4'h0;
      end else if (wrControl) begin
         timer1Run_reg <= sfrWrData[`TTC_CTL_T1_RUN];
         timer0Run_reg <= sfrWrData[`TTC_CTL_T0_RUN];
         extIntBits_reg <= sfrWrData[3:0];
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= `TTC_RST_BYTE;
      end else if (wrMode) begin
         mode_reg <= sfrWrData;
      end
   end

   // Timer 2 bytes kept only so software sees its own writes
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         t2Control_reg <= `TTC_RST_BYTE;
         t2ReloadLow_reg <= `TTC_RST_BYTE;
         t2ReloadHigh_reg <= `TTC_RST_BYTE;
         t2Low_reg <= `TTC_RST_BYTE;
         t2High_reg <= `TTC_RST_BYTE;
      end else if (sfrWrEn) begin
         case (sfrAddr)
            `TTC_ADDR_T2_CONTROL: begin
               t2Control_reg <= sfrWrData;
            end
            `TTC_ADDR_T2_RELOAD_LOW: begin
               t2ReloadLow_reg <= sfrWrData;
            end
            `TTC_ADDR_T2_RELOAD_HIGH: begin
               t2ReloadHigh_reg <= sfrWrData;
            end
            `TTC_ADDR_T2_LOW: begin
               t2Low_reg <= sfrWrData;
            end
            `TTC_ADDR_T2_HIGH: begin
               t2High_reg <= sfrWrData;
            end
            default: begin
               t2Control_reg <= t2Control_reg;
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      case (sfrAddr)
         `TTC_ADDR_CONTROL: begin
            readMux = {timer1OverflowFlag, timer1Run_reg, timer0OverflowFlag,
                       timer0Run_reg, extIntBits_reg};
         end
         `TTC_ADDR_MODE: begin
            readMux = mode_reg;
         end
         `TTC_ADDR_T0_LOW: begin
            readMux = timer0Low;
         end
         `TTC_ADDR_T1_LOW: begin
            readMux = timer1Low;
         end
         `TTC_ADDR_T0_HIGH: begin
            readMux = timer0High;
         end
         `TTC_ADDR_T1_HIGH: begin
            readMux = timer1High;
         end
         `TTC_ADDR_T2_CONTROL: begin
            readMux = t2Control_reg;
         end
         `TTC_ADDR_T2_RELOAD_LOW: begin
            readMux = t2ReloadLow_reg;
         end
         `TTC_ADDR_T2_RELOAD_HIGH: begin
            readMux = t2ReloadHigh_reg;
         end
         `TTC_ADDR_T2_LOW: begin
            readMux = t2Low_reg;
         end
         `TTC_ADDR_T2_HIGH: begin
            readMux = t2High_reg;
         end
         default: begin
            readMux = 8'h00;
         end
      endcase
   end

   // Registered read keeps the output straight from a flop; data lags by one cycle
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sfrRdData <= 8'h00;
      end else if (sfrRdEn) begin
         sfrRdData <= readMux;
      end
   end

endmodule // ttc_timer_unit

// >>> sim/testbench.sv
// Purpose: Register-level tests of the timer unit.
// Assumes: Stimulus changes at the rising edge.
// Notes: A burst gives 32 increments, fixed by the write timing.
`timescale 1ns/10ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h expected %h", $time, a, e); end end
module testbench;
   logic clk_sys = 0;
   logic rstn = 0;
   logic [7:0] sfrAddr = 0, sfrWrData = 0, d, v;
   logic sfrWrEn = 0, sfrRdEn = 0, ack0 = 0, ack1 = 0, timer0_pin_gating = 0, timer1_pin_gating = 0;
   logic start0 = 0, start1 = 0;
   wire [7:0] rdData;
   wire flag0, flag1, pin0, pin1, busy0, busy1;
   int errors = 0, samplesChecked = 0;
   logic [7:0] addrs [11] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca,
      8'hcb, 8'hcc, 8'hcd};
   ttc_timer_unit i_dut (.clk_sys(clk_sys), .rstn(rstn), .sfrAddr(sfrAddr),
      .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(rdData),
      .timer0VectorAck(ack0), .timer1VectorAck(ack1), .countInputZero(pin0),
      .countInputOne(pin1), .gatePinZero(timer0_pin_gating), .gatePinOne(timer1_pin_gating),
      .timer0OverflowFlag(flag0), .timer1OverflowFlag(flag1));
   ttc_pin_model i_pin0 (.clk_sys(clk_sys), .rstn(rstn), .start(start0), .edges(8'h05),
      .hold(4'h0), .countPin(pin0), .busy(busy0));
   ttc_pin_model i_pin1 (.clk_sys(clk_sys), .rstn(rstn), .start(start1), .edges(8'h07),
      .hold(4'h2), .countPin(pin1), .busy(busy1));
   initial forever #4 clk_sys = ~clk_sys;
   task automatic summarize;
      if (errors == 0 && samplesChecked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Write strobe stays up until a read or a pause lowers it
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      sfrWrEn <= 1'b1;
      sfrAddr <= a;
      sfrWrData <= x;
      @(posedge clk_sys);
   endtask
   task automatic nap(input int n);
      sfrWrEn <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      sfrWrEn <= 1'b0;
      sfrRdEn <= 1'b1;
      sfrAddr <= a;
      @(posedge clk_sys);
      sfrRdEn <= 1'b0;
      @(posedge clk_sys);
      x = rdData;
   endtask
   task automatic ld(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi,
      input logic t);
      wr(8'h89, m);
      wr(8'h8a + t, lo);
      wr(8'h8c + t, hi);
   endtask
   task automatic burst(input logic [7:0] run, input logic [1:0] f);
      wr(8'h88, run);
      nap(31);
      `CHK({flag1, flag0}, f)
      wr(8'h88, 8'h00);
   endtask
   task automatic look(input logic t, input logic [7:0] lo, input logic [7:0] hi);
      rd(8'h8a + t, d);
      `CHK(d, lo)
      rd(8'h8c + t, d);
      `CHK(d, hi)
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      foreach (addrs[i]) begin
         v = (i == 0) ? 8'h0a : addrs[i] ^ 8'h5a;
         wr(addrs[i], v);
         rd(addrs[i], d);
         `CHK(d, v)
      end
      wr(8'h8e, 8'hff);
      rd(8'h8e, d);
      `CHK(d, 8'h00)
      rstn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      foreach (addrs[i]) begin
         rd(addrs[i], d);
         `CHK(d, 8'h00)
      end
      ld(8'h01, 8'hf0, 8'hff, 0);
      burst(8'h10, 2'b01);
      look(0, 8'h10, 8'h00);
      ld(8'h00, 8'he2, 8'hff, 1);
      burst(8'h40, 2'b10);
      look(1, 8'he2, 8'h00);
      ld(8'h02, 8'hfe, 8'hc0, 0);
      burst(8'h10, 2'b01);
      look(0, 8'hde, 8'hc0);
      ld(8'h20, 8'h1e, 8'h7f, 0);
      ld(8'h20, 8'hfe, 8'h40, 1);
      burst(8'h50, 2'b10);
      look(0, 8'h1e, 8'h80);
      look(1, 8'h5e, 8'h40);
      ld(8'h30, 8'h55, 8'h66, 1);
      burst(8'h40, 2'b00);
      look(1, 8'h55, 8'h66);
      ld(8'h33, 8'h00, 8'h00, 0);
      burst(8'h40, 2'b00);
      look(0, 8'h00, 8'h20);
      ld(8'h99, 8'h00, 8'h00, 0);
      ld(8'h99, 8'h00, 8'h00, 1);
      burst(8'h50, 2'b00);
      look(0, 8'h00, 8'h00);
      look(1, 8'h00, 8'h00);
      timer0_pin_gating <= 1'b1;
      timer1_pin_gating <= 1'b1;
      nap(4);
      burst(8'h50, 2'b00);
      look(0, 8'h20, 8'h00);
      look(1, 8'h20, 8'h00);
      ld(8'h55, 8'h00, 8'h00, 0);
      ld(8'h55, 8'h00, 8'h00, 1);
      wr(8'h88, 8'h50);
      nap(1);
      start0 <= 1'b1;
      start1 <= 1'b1;
      @(posedge clk_sys);
      start0 <= 1'b0;
      start1 <= 1'b0;
      nap(2);
      for (int n = 0; n < 200 && (busy0 || busy1); n++) @(posedge clk_sys);
      nap(8);
      wr(8'h88, 8'h00);
      look(0, 8'h05, 8'h00);
      look(1, 8'h07, 8'h00);
      wr(8'h88, 8'ha0);
      nap(1);
      `CHK({flag1, flag0}, 2'b11)
      ack0 <= 1'b1;
      ack1 <= 1'b1;
      @(posedge clk_sys);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      @(posedge clk_sys);
      `CHK({flag1, flag0}, 2'b00)
      summarize();
   end
endmodule // testbench

// >>> sim/ttc_pin_model.sv
// Purpose: Source for one external count pin of the timer unit.
// Assumes: The pin idles high, as with a pulled-up input.
// Notes: Sends a burst of falling edges on request.
`timescale 1ns/10ps
module ttc_pin_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Burst request
   input wire logic start,
   input wire logic [7:0] edges,
   input wire logic [3:0] hold,
   // Pin and status
   output logic countPin,
   output logic busy
);
   logic [8:0] togglesLeft;
   logic [3:0] holdCnt;
   assign busy = togglesLeft != 9'h000;
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         countPin <= 1'b1;
         togglesLeft <= 9'h000;
         holdCnt <= 4'h0;
      end else if (start && !busy) begin
         togglesLeft <= {edges, 1'b0};
         holdCnt <= hold;
      end else if (holdCnt != 4'h0) begin
         holdCnt <= holdCnt - 4'h1;
      end else if (busy) begin
         countPin <= ~countPin;
         togglesLeft <= togglesLeft - 9'h001;
         holdCnt <= hold;
      end
   end
endmodule // ttc_pin_model

// >>> sim/ttc_timer_unit_chk.sv
// Purpose: Port assertions for the timer unit.
// Assumes: One clock domain.
// Notes: Count values are judged by the bench.
`timescale 1ns/10ps
module ttc_timer_unit_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrRdEn,
   input wire logic [7:0] sfrRdData,
   // Acks and flags
   input wire logic timer0VectorAck,
   input wire logic timer1VectorAck,
   input wire logic timer0OverflowFlag,
   input wire logic timer1OverflowFlag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence sWr(a);
      sfrWrEn && sfrAddr == a;
   endsequence
   sequence sRd(a);
      sfrRdEn && !sfrWrEn && sfrAddr == a;
   endsequence
   AST_MODE_READBACK: assert property (sWr(8'h89) ##1 sRd(8'h89)
      |=> sfrRdData == $past(sfrWrData, 2)) else $error("mode readback differs");
   AST_T2_READBACK: assert property (sWr(8'hcd) ##1 sRd(8'hcd)
      |=> sfrRdData == $past(sfrWrData, 2)) else $error("storage readback differs");
   // Flags are left out: hardware may set them at any time
   AST_RUN_READBACK: assert property (sWr(8'h88) ##1 sRd(8'h88)
      |=> (sfrRdData & 8'h5f) == ($past(sfrWrData, 2) & 8'h5f))
      else $error("control readback differs");
   AST_FLAG_READBACK: assert property (sRd(8'h88) |=> sfrRdData[7] == $past(timer1OverflowFlag)
      && sfrRdData[5] == $past(timer0OverflowFlag)) else $error("flag readback differs");
   AST_UNMAPPED_ZERO: assert property (sRd(8'h8e) |=> sfrRdData == 8'h00)
      else $error("unmapped read not zero");
   AST_RD_HOLD: assert property (!sfrRdEn |=> $stable(sfrRdData))
      else $error("read data moved");
   AST_FLAG0_CLEAR: assert property ($fell(timer0OverflowFlag) |-> $past(timer0VectorAck)
      || ($past(sfrWrEn) && $past(sfrAddr) == 8'h88)) else $error("flag 0 cleared");
   AST_FLAG1_CLEAR: assert property ($fell(timer1OverflowFlag) |-> $past(timer1VectorAck)
      || ($past(sfrWrEn) && $past(sfrAddr) == 8'h88)) else $error("flag 1 cleared");
   AST_FLAG_SET: assert property (sWr(8'h88) ##0 sfrWrData[7] |=> timer1OverflowFlag)
      else $error("flag 1 not set");
endmodule // ttc_timer_unit_chk
bind ttc_timer_unit ttc_timer_unit_chk i_chk (.clk_sys(clk_sys), .rstn(rstn),
   .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
   .sfrRdData(sfrRdData), .timer0VectorAck(timer0VectorAck),
   .timer1VectorAck(timer1VectorAck), .timer0OverflowFlag(timer0OverflowFlag),
   .timer1OverflowFlag(timer1OverflowFlag));
